// *** rtl/cts_capture_mem.v ***
/*
 circular capture memory with write pointer.
 assumes writes only while the sequencer records.
*/
`timescale 1ns/1ps
module cts_capture_mem #(
  parameter W = 18,
  parameter DEPTH = 1024,
  parameter AW = 10
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_clear,
  input wire i_we,
  input wire [W-1:0] i_data,
  input wire [AW-1:0] i_raddr,
  output reg [W-1:0] o_rdata,
  output reg [AW-1:0] o_waddr
);
  reg [W-1:0] mem [0:DEPTH-1];
  // ------------------------------------------------------------
  // write and read ports
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[o_waddr] <= i_data;
    end
    o_rdata <= mem[i_raddr];
  end
  always @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      o_waddr <= {AW{1'b0}};
    end else if (i_we) begin
      o_waddr <= o_waddr + {{(AW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// *** rtl/cts_defs.vh ***
/*
 capture trigger sequencer constants: sizes, offsets, mode codes, reset values.
 assumes inclusion by bare name from the rtl files; definitions only.
*/
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH
// ------------------------------------------------------------
// register map (word offsets are byte addresses)
// ------------------------------------------------------------
`define CTS_REG_CTRL 8'h00
`define CTS_REG_DELAY 8'h04
`define CTS_REG_EN_VAL 8'h08
`define CTS_REG_EN_CARE 8'h0c
`define CTS_REG_TR_VAL 8'h10
`define CTS_REG_TR_CARE 8'h14
`define CTS_REG_STATUS 8'h18
`define CTS_REG_WADDR 8'h1c
`define CTS_REG_CHMASK 8'h20
`define CTS_REG_HEXLD 8'h24
// ------------------------------------------------------------
// ctrl fields
// ------------------------------------------------------------
`define CTS_CTRL_ARM 0
`define CTS_CTRL_DLY_EVT 1
`define CTS_CTRL_EN_FALSE 2
`define CTS_CTRL_MAN_SEL 3
`define CTS_CTRL_TR_MAN 4
`define CTS_CTRL_AUTO 5
// ------------------------------------------------------------
// enable mode codes
// ------------------------------------------------------------
`define CTS_EMODE_AUTO 2'h0
`define CTS_EMODE_MAN 2'h1
`define CTS_EMODE_COMB 2'h2
// ------------------------------------------------------------
// timing and capture memory
// ------------------------------------------------------------
`define CTS_MEM_WORDS 1024
`define CTS_FIXED_OFFSET 23
`define CTS_DELAY_RESET 16'h01f4
`define CTS_EVT_SLOT 501
`define CTS_WIDTH 18
`endif

// *** rtl/cts_pattern_cmp.v ***
/*
 tri-state pattern comparator for one stage (data plus two qualifiers).
 assumes inputs already synchronised to i_clk.
*/
`timescale 1ns/1ps
module cts_pattern_cmp #(
  parameter W = 18
) (
  input wire [W-1:0] i_sample,
  input wire [W-1:0] i_value,
  input wire [W-1:0] i_care,
  input wire [W-1:0] i_chmask,
  output wire o_match
);
  wire [W-1:0] bit_ok;
  genvar g;
  // ------------------------------------------------------------
  // per-position compare
  // ------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_pos
      // a position counts only if marked 1/0 and not truncated
      assign bit_ok[g] = ~(i_care[g] & i_chmask[g]) | (i_sample[g] == i_value[g]);
    end
  endgenerate
  assign o_match = &bit_ok;
endmodule

// *** rtl/cts_sequencer.v ***
/*
 capture trigger sequencer: arm, enable, trigger, post-trigger delay,
 with a classic wishbone slave for setup and status and a capture memory.
 assumes probes and qualifiers are asynchronous pins; manual switches are
 debounced outside and arrive as levels.
*/
// ------------------------------------------------------------
// Notes on behaviour
// - stages run strictly arm, enable, trigger; trigger decides what memory keeps.
// - after arming, enable must occur before trigger matches count.
// - a control bit picks delay in clocks or in trigger occurrences.
// - occurrence mode counts n matches, n+1th lands at word 501.
// - delay applies to trigger only, never to enable.
// - fixed 23-word offset is added to every clock-mode delay; occurrence mode adds none.
// - patterns are 16 data positions plus two qualifier positions.
// - automatic enable, the reset default, skips the enable stage.
// - manual enable ignores the pattern, waits for the manual pulse.
// - writing the enable pattern selects combinational enable.
// - manual pulse finishing a combinational run leaves mode manual.
// - positions are one, zero or don't care; hex load sets four.
// - true polarity enables when all cared positions match.
// - false polarity finds the match, enables when it is lost.
// - qualifier positions set separately for enable and trigger.
// - truncated channels are left out of matching; hidden ones are not.
// - clock mode records delay periods after trigger; default 500.
// - delay zero puts the trigger sample at word 1000.
// - trigger stage is combinational or manual, never automatic.
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "cts_defs.vh"
module cts_sequencer #(
  parameter W = `CTS_WIDTH,
  parameter DEPTH = `CTS_MEM_WORDS,
  parameter AW = 10
) (
  input wire i_clk,
  input wire i_rst,
  input wire [15:0] i_probe,
  input wire i_first_qualifier_bit,
  input wire i_second_qualifier_bit,
  input wire i_man_enable,
  input wire i_man_trigger,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  output wire o_recording,
  output wire o_done
);
  localparam S_IDLE = 5'h01;
  localparam S_EN = 5'h02;
  localparam S_TRIG = 5'h04;
  localparam S_POST = 5'h08;
  localparam S_DONE = 5'h10;
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [W+1:0] sync1_q;
  reg [W+1:0] sync2_q;
  // previous switch levels reset low, the idle level, so reset gives no false edge
  reg [1:0] man_prev_q;
  wire [W-1:0] sample = sync2_q[W-1:0];
  wire man_en_lvl = sync2_q[W];
  wire man_tr_lvl = sync2_q[W+1];
  wire man_en_pulse = man_en_lvl & ~man_prev_q[0];
  wire man_tr_pulse = man_tr_lvl & ~man_prev_q[1];
  always @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= {(W+2){1'b0}};
      sync2_q <= {(W+2){1'b0}};
      man_prev_q <= 2'h0;
    end else begin
      sync1_q <= {i_man_trigger, i_man_enable, i_second_qualifier_bit,
                  i_first_qualifier_bit, i_probe};
      sync2_q <= sync1_q;
      man_prev_q <= {man_tr_lvl, man_en_lvl};
    end
  end
  // ------------------------------------------------------------
  // setup registers
  // ------------------------------------------------------------
  reg [5:0] ctrl_q;
  reg [15:0] delay_q;
  reg [W-1:0] en_val_q;
  reg [W-1:0] en_care_q;
  reg [W-1:0] tr_val_q;
  reg [W-1:0] tr_care_q;
  reg [W-1:0] chmask_q;
  reg [1:0] emode_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [AW-1:0] raddr_q;
  reg seen_q;
  reg [15:0] cnt_q;
  reg [15:0] post_q;
  wire wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  wire rd = i_wb_cyc & i_wb_stb & ~i_wb_we & ~o_wb_ack;
  wire arm_wr = wr && i_wb_adr == `CTS_REG_CTRL && i_wb_sel[0] && i_wb_dat[`CTS_CTRL_ARM];
  wire [3:0] hex_pos = i_wb_dat[11:8];
  wire [3:0] hex_dig = i_wb_dat[3:0];
  wire hex_tr = i_wb_dat[16];
  wire [W-1:0] hex_mask = {{(W-4){1'b0}}, 4'hf} << {hex_pos[1:0], 2'h0};
  wire [W-1:0] hex_bits = {{(W-4){1'b0}}, hex_dig} << {hex_pos[1:0], 2'h0};
  wire en_comb_done;
  wire en_man_done;
  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= 6'h00;
      delay_q <= `CTS_DELAY_RESET;
      en_val_q <= {W{1'b0}};
      en_care_q <= {W{1'b0}};
      tr_val_q <= {W{1'b0}};
      tr_care_q <= {W{1'b0}};
      chmask_q <= {W{1'b1}};
      emode_q <= `CTS_EMODE_AUTO;
      raddr_q <= {AW{1'b0}};
    end else begin
      if (wr) begin
        case (i_wb_adr)
          `CTS_REG_CTRL: begin
            ctrl_q <= {i_wb_dat[5:1], 1'b0};
            if (i_wb_dat[`CTS_CTRL_MAN_SEL]) begin
              emode_q <= `CTS_EMODE_MAN;
            end else if (i_wb_dat[`CTS_CTRL_AUTO]) begin
              emode_q <= `CTS_EMODE_AUTO;
            end
          end
          `CTS_REG_DELAY: delay_q <= i_wb_dat[15:0];
          `CTS_REG_EN_VAL: begin
            en_val_q <= i_wb_dat[W-1:0];
            emode_q <= `CTS_EMODE_COMB;
          end
          `CTS_REG_EN_CARE: begin
            en_care_q <= i_wb_dat[W-1:0];
            emode_q <= `CTS_EMODE_COMB;
          end
          `CTS_REG_TR_VAL: tr_val_q <= i_wb_dat[W-1:0];
          `CTS_REG_TR_CARE: tr_care_q <= i_wb_dat[W-1:0];
          `CTS_REG_CHMASK: chmask_q <= i_wb_dat[W-1:0];
          `CTS_REG_WADDR: raddr_q <= i_wb_dat[AW-1:0];
          `CTS_REG_HEXLD: begin
            // one hex digit fills four positions, all cared
            if (hex_tr) begin
              tr_val_q <= (tr_val_q & ~hex_mask) | hex_bits;
              tr_care_q <= tr_care_q | hex_mask;
            end else begin
              en_val_q <= (en_val_q & ~hex_mask) | hex_bits;
              en_care_q <= en_care_q | hex_mask;
              emode_q <= `CTS_EMODE_COMB;
            end
          end
          default: begin
          end
        endcase
      end else if (emode_q == `CTS_EMODE_COMB && en_man_done) begin
        emode_q <= `CTS_EMODE_MAN;
      end
    end
  end
  // ------------------------------------------------------------
  // comparators and capture memory
  // ------------------------------------------------------------
  wire en_match;
  wire tr_match;
  wire [W-1:0] mem_rdata;
  wire [AW-1:0] waddr;
  cts_pattern_cmp #(.W(W)) u_en_cmp (
    .i_sample(sample),
    .i_value(en_val_q),
    .i_care(en_care_q),
    .i_chmask(chmask_q),
    .o_match(en_match)
  );
  cts_pattern_cmp #(.W(W)) u_tr_cmp (
    .i_sample(sample),
    .i_value(tr_val_q),
    .i_care(tr_care_q),
    .i_chmask(chmask_q),
    .o_match(tr_match)
  );
  wire recording = (state_q == S_EN) | (state_q == S_TRIG) | (state_q == S_POST);
  cts_capture_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(arm_wr),
    .i_we(recording),
    .i_data(sample),
    .i_raddr(raddr_q),
    .o_rdata(mem_rdata),
    .o_waddr(waddr)
  );
  // ------------------------------------------------------------
  // enable and trigger detection
  // ------------------------------------------------------------
  // false polarity waits for a match first, then fires when it is lost
  wire en_false = ctrl_q[`CTS_CTRL_EN_FALSE];
  assign en_comb_done = en_false ? (seen_q & ~en_match) : en_match;
  assign en_man_done = (state_q == S_EN) & man_en_pulse;
  wire en_hit = (emode_q == `CTS_EMODE_MAN) ? man_en_pulse :
                (emode_q == `CTS_EMODE_COMB) ? (en_comb_done | man_en_pulse) : 1'b0;
  wire tr_hit = ctrl_q[`CTS_CTRL_TR_MAN] ? man_tr_pulse : tr_match;
  wire dly_evt = ctrl_q[`CTS_CTRL_DLY_EVT];
  // occurrences are matching samples: a match held n clocks counts n times
  // event mode: trigger lands at slot 501 of 0..1023, so 522 words follow it
  wire [31:0] evt_sum = `CTS_MEM_WORDS - 1 - `CTS_EVT_SLOT;
  wire [15:0] evt_post = evt_sum[15:0];
  // clock mode: delay plus the fixed offset words follow the trigger word
  wire [31:0] clk_sum = {16'h0000, delay_q} + `CTS_FIXED_OFFSET;
  wire [15:0] clk_post = clk_sum[15:0];
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        // a mode select in the arming write itself does not pick this run's first stage
        if (arm_wr) begin
          state_d = (emode_q == `CTS_EMODE_AUTO) ? S_TRIG : S_EN;
        end
      end
      S_EN: begin
        if (en_hit) begin
          state_d = S_TRIG;
        end
      end
      S_TRIG: begin
        if (tr_hit && (!dly_evt || cnt_q == delay_q)) begin
          state_d = S_POST;
        end
      end
      S_POST: begin
        // post_q counts words still to write; the last one is written at one
        if (post_q == 16'h0001) begin
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        if (arm_wr) begin
          state_d = (emode_q == `CTS_EMODE_AUTO) ? S_TRIG : S_EN;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      seen_q <= 1'b0;
      cnt_q <= 16'h0000;
      post_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_q != S_EN) begin
        seen_q <= 1'b0;
      end else if (en_match) begin
        seen_q <= 1'b1;
      end
      if (state_q != S_TRIG) begin
        cnt_q <= 16'h0000;
      end else if (tr_hit) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      if (state_q == S_TRIG) begin
        post_q <= dly_evt ? evt_post : clk_post;
      end else if (state_q == S_POST && post_q != 16'h0000) begin
        post_q <= post_q - 16'h0001;
      end
    end
  end
  assign o_recording = recording;
  assign o_done = (state_q == S_DONE);
  // ------------------------------------------------------------
  // wishbone read and ack
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= (wr | rd);
      if (rd) begin
        case (i_wb_adr)
          `CTS_REG_CTRL: o_wb_dat <= {26'h0000000, ctrl_q};
          `CTS_REG_DELAY: o_wb_dat <= {16'h0000, delay_q};
          `CTS_REG_EN_VAL: o_wb_dat <= {14'h0000, en_val_q};
          `CTS_REG_EN_CARE: o_wb_dat <= {14'h0000, en_care_q};
          `CTS_REG_TR_VAL: o_wb_dat <= {14'h0000, tr_val_q};
          `CTS_REG_TR_CARE: o_wb_dat <= {14'h0000, tr_care_q};
          `CTS_REG_STATUS: o_wb_dat <= {9'h000, waddr, 6'h00, emode_q, state_q};
          `CTS_REG_WADDR: o_wb_dat <= {14'h0000, mem_rdata};
          `CTS_REG_CHMASK: o_wb_dat <= {14'h0000, chmask_q};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// *** sim/cts_props.sv ***
/*
 checker for cts_sequencer: bus answer and run states at the ports.
 assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
module cts_props (
  input wire i_clk,
  input wire i_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire o_recording,
  input wire o_done
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // an arm write is the only legal way out of done
  wire arm = req && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[0] && i_wb_dat[0];
  ack_on_req_a: assert property (req |=> o_wb_ack)
    else $error("no ack after request");
  ack_one_shot_a: assert property (!req |=> !o_wb_ack)
    else $error("ack without request");
  unmapped_zero_a: assert property (req && !i_wb_we && i_wb_adr == 8'h28 |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  run_exclusive_a: assert property (!(o_recording && o_done))
    else $error("recording and done together");
  done_hold_a: assert property (o_done && !arm |=> o_done)
    else $error("done dropped without arm");
  rec_hold_a: assert property (o_recording && !arm |=> o_recording || o_done)
    else $error("recording stopped without done");
  arm_starts_a: assert property (arm |-> ##[1:4] o_recording)
    else $error("arm did not start recording");
  done_after_rec_a: assert property ($rose(o_done) |-> $past(o_recording))
    else $error("done not preceded by recording");
  post_offset_a: assert property ($rose(o_done) |-> $past(o_recording, 20))
    else $error("stop came before fixed offset");
  cover property (arm);
  cover property ($rose(o_done));
  cover property (o_wb_ack && !i_wb_we);
endmodule
bind cts_sequencer cts_props chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_recording(o_recording), .o_done(o_done)
);

// *** sim/cts_sequencer_test.sv ***
/*
 bench for cts_sequencer: bus setup, probe words through the model,
 trigger position read back from capture memory.
 assumes a one-cycle bus answer and the 20 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons = comparisons + 1; if ((a) !== (b)) begin \
  err_total = err_total + 1; $display("CHECK FAILED %0t got %0h want %0h", $time, (a), (b)); end end
module cts_sequencer_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, en_p = 1'b0, tr_p = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, rv, wa;
  reg [17:0] word = 18'h0;
  wire [31:0] rdat;
  wire [17:0] pins;
  wire ack, rec, done, men, mtr;
  integer err_total = 0, comparisons = 0, k;
  always #25 clk = ~clk;
  cts_sequencer dut_u (.i_clk(clk), .i_rst(rst), .i_probe(pins[15:0]),
    .i_first_qualifier_bit(pins[16]), .i_second_qualifier_bit(pins[17]),
    .i_man_enable(men), .i_man_trigger(mtr), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_recording(rec), .o_done(done));
  cts_target_model src_u (.i_clk(clk), .i_word(word), .i_en_press(en_p),
    .i_tr_press(tr_p), .o_pins(pins), .o_man_enable(men), .o_man_trigger(mtr));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      rv = rdat;
      `CHK(ack, 1'b1)
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task mem(input [9:0] a, input [17:0] e);
    begin
      wb(1'b1, 8'h1c, {22'h0, a});
      wb(1'b0, 8'h1c, 32'h0);
      `CHK(rv[17:0], e)
    end
  endtask
  // bounded wait; the caller compares done afterwards
  task waitd(input integer lim);
    integer n;
    begin
      n = 0;
      while (done !== 1'b1 && n < lim) begin
        n = n + 1;
        @(posedge clk);
      end
    end
  endtask
  // switch held four clocks so the synchroniser surely sees one edge
  task push(input t);
    begin
      if (t) tr_p <= 1'b1;
      else en_p <= 1'b1;
      repeat (4) @(posedge clk);
      tr_p <= 1'b0;
      en_p <= 1'b0;
    end
  endtask
  task arm_quiet(input [31:0] c);
    begin
      wb(1'b1, 8'h00, c);
      repeat (30) @(posedge clk);
      `CHK(done, 1'b0)
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #4000000;
    err_total = err_total + 1;
    summarize;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rv[6:0], 7'h01)
    wb(1'b0, 8'h04, 32'h0);
    `CHK(rv[15:0], 16'h01f4)
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rv[15:0], 16'hffff)
    wb(1'b1, 8'h28, 32'hffffffff);
    wb(1'b0, 8'h28, 32'h0);
    `CHK(rv, 32'h0)
    $display("test reset ends");
    // qualifier cared in the trigger word, so a zero word never matches
    wb(1'b1, 8'h10, 32'h11234);
    wb(1'b1, 8'h14, 32'h1ffff);
    for (k = 0; k < 2; k = k + 1) begin
      wb(1'b1, 8'h04, k * 5);
      arm_quiet(32'h1);
      `CHK(rec, 1'b1)
      word <= 18'h11234;
      waitd(100);
      `CHK(done, 1'b1)
      wb(1'b0, 8'h18, 32'h0);
      wa = rv[22:13] - 24 - k * 5;
      mem(wa[9:0], 18'h11234);
      mem(wa[9:0] - 10'h1, 18'h0);
      word <= 18'h0;
    end
    $display("test clock delay ends");
    wb(1'b1, 8'h04, 32'h2);
    arm_quiet(32'h3);
    for (k = 0; k < 3; k = k + 1) begin
      word <= 18'h11234;
      @(posedge clk);
      word <= 18'h0;
      repeat (5) @(posedge clk);
    end
    waitd(600);
    `CHK(done, 1'b1)
    wb(1'b0, 8'h18, 32'h0);
    wa = rv[22:13] - 523;
    mem(wa[9:0], 18'h11234);
    mem(wa[9:0] - 10'h6, 18'h11234);
    mem(wa[9:0] + 10'h1, 18'h0);
    $display("test event delay ends");
    wb(1'b1, 8'h00, 32'h8);
    word <= 18'h11234;
    arm_quiet(32'h9);
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rv[6:0], 7'h22)
    push(1'b0);
    waitd(100);
    `CHK(done, 1'b1)
    wb(1'b1, 8'h08, 32'h000aa);
    wb(1'b1, 8'h0c, 32'h0ffff);
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rv[6:5], 2'h2)
    arm_quiet(32'h1);
    word <= 18'h000aa;
    repeat (5) @(posedge clk);
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rv[4:0], 5'h04)
    word <= 18'h11234;
    waitd(100);
    `CHK(done, 1'b1)
    arm_quiet(32'h5);
    word <= 18'h000aa;
    repeat (5) @(posedge clk);
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rv[4:0], 5'h02)
    word <= 18'h11234;
    waitd(100);
    `CHK(done, 1'b1)
    arm_quiet(32'h1);
    push(1'b0);
    waitd(100);
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rv[6:0], 7'h30)
    $display("test enable modes ends");
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h24, 32'h1030f);
    wb(1'b1, 8'h00, 32'h20);
    word <= 18'h00fff;
    arm_quiet(32'h21);
    word <= 18'h0f000;
    waitd(100);
    `CHK(done, 1'b1)
    wb(1'b1, 8'h20, 32'h30fff);
    word <= 18'h00fff;
    wb(1'b1, 8'h00, 32'h21);
    waitd(100);
    `CHK(done, 1'b1)
    arm_quiet(32'h11);
    push(1'b1);
    waitd(100);
    `CHK(done, 1'b1)
    $display("test patterns ends");
    summarize;
  end
endmodule

// *** sim/cts_target_model.sv ***
/*
 model of the monitored system: probes, qualifiers and the two switches.
 assumes the bench gives the next word; it appears one clock later.
*/
`timescale 1ns/1ps
module cts_target_model (
  input wire i_clk,
  input wire [17:0] i_word,
  input wire i_en_press,
  input wire i_tr_press,
  output reg [17:0] o_pins,
  output reg o_man_enable,
  output reg o_man_trigger
);
  // ----------------------------------------
  // clocked source
  // ----------------------------------------
  initial begin
    o_pins = 18'h0;
    o_man_enable = 1'b0;
    o_man_trigger = 1'b0;
  end
  always @(posedge i_clk) begin
    o_pins <= i_word;
    o_man_enable <= i_en_press;
    o_man_trigger <= i_tr_press;
  end
endmodule
